/* File: include/sync_ctrl_pkg.sv */
package sync_ctrl_pkg;

  // Number of output groups, each with its own delay and exclude bit
  localparam int NUM_GROUPS = 6;
  // Width of the coarse delay field (5 to 522 needs ten bits)
  localparam int COARSE_W = 10;
  // Width of the loop 2 feedback divide field
  localparam int LOOP2_DIV_W = 18;
  // Byte address width of the register window
  localparam int ADDR_W = 8;

  // Byte offsets of the registers
  localparam logic [ADDR_W-1:0] GROUP0_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] LOOP2_DIV_OFFSET = 8'h78;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h80;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h84;

  // Field positions inside a group register
  localparam int GROUP_COARSE_LSB = 0;
  localparam int GROUP_HALF_STEP_BIT = 16;
  localparam int GROUP_EXCLUDE_BIT = 24;
  // Field positions inside the status register
  localparam int STATUS_LATCHED_BIT = 0;
  localparam int STATUS_HOLD_BIT = 1;
  localparam int STATUS_RUN_LSB = 8;

  // Sync latency in distribution cycles, from latch to output change
  localparam int SYNC_LATENCY = 6;
  // Stages of the sync request synchroniser
  localparam int SYNC_STAGES = 2;
  // Length of the internal request raised by a register write
  localparam int WRITE_SYNC_CYCLES = 3;
  // Lowest sync type at which the sync pin acts as an output
  localparam logic [2:0] SYNC_TYPE_OUT_MIN = 3'h3;

  // Reset values
  localparam logic [COARSE_W-1:0] COARSE_RESET = 10'h005;
  localparam logic [LOOP2_DIV_W-1:0] LOOP2_DIV_RESET = 18'h00001;

  // Global control register, bit 10 downward
  typedef struct packed {
    logic out4_ref_source_sel;   // Bit 10: output_four from reference
    logic out3_ref_source_sel;   // Bit 9: output_three from reference
    logic internal_vco;          // Bit 8: internal oscillator in use
    logic loop2_unlock_sync;     // Bit 7
    logic loop1_unlock_sync;     // Bit 6
    logic auto_sync;             // Bit 5: group writes raise a sync
    logic [2:0] sync_type;       // Bits 4:2
    logic sync_polarity_invert;  // Bit 1
    logic sync_enable;           // Bit 0
  } ctrl_s;

  localparam logic [10:0] CTRL_RESET = 11'h101;

  // One group's programmed delay settings
  typedef struct packed {
    logic group_sync_exclude;
    logic half_step_delay;
    logic [COARSE_W-1:0] coarse_delay_count;
  } group_cfg_s;

  // Output group sequencing states
  typedef enum logic [2:0] {
    GRP_RUN = 3'b001,
    GRP_HELD = 3'b010,
    GRP_DELAY = 3'b100
  } group_state_e;

endpackage : sync_ctrl_pkg

/* File: design/sync_group_delay.sv */
`timescale 1ns/1ps
`default_nettype none

// One output group: held low by sync, restarted after latency plus delay
module sync_group_delay #(
  parameter int COARSE_W = sync_ctrl_pkg::COARSE_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic participate,
  input wire logic assert_pulse,
  input wire logic release_pulse,
  input wire logic [COARSE_W-1:0] coarse_cfg,
  input wire logic half_step_cfg,
  output logic group_run_q,
  output logic half_step_q
);

  // Room for the largest coarse count
  localparam int CNT_W = COARSE_W + 1;
  // Release arrives a full latency after its latch edge, so the wait
  // loaded here is one short of the coarse count
  localparam logic [CNT_W-1:0] LOAD_TRIM = CNT_W'(1);

  sync_ctrl_pkg::group_state_e state_q;  // Current sequencing state
  sync_ctrl_pkg::group_state_e state_d;  // Next state
  logic [CNT_W-1:0] cnt_q;  // Cycles left before the restart
  logic [CNT_W-1:0] cnt_d;
  wire logic cnt_done = (cnt_q == '0);
  // Coarse count is sampled only here, when the release pulse arrives
  wire logic [CNT_W-1:0] cnt_load = {1'b0, coarse_cfg} - LOAD_TRIM;

  // State sequencing; excluded groups never leave the run state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      sync_ctrl_pkg::GRP_RUN: begin
        if (assert_pulse && participate) begin
          // Forced low on any phase; a runt pulse outside is accepted
          state_d = sync_ctrl_pkg::GRP_HELD;
        end
      end
      sync_ctrl_pkg::GRP_HELD: begin
        if (release_pulse) begin
          state_d = sync_ctrl_pkg::GRP_DELAY;
          cnt_d = cnt_load;
        end
      end
      sync_ctrl_pkg::GRP_DELAY: begin
        // A fresh sync during the restart wait holds the group again
        if (assert_pulse && participate) begin
          state_d = sync_ctrl_pkg::GRP_HELD;
        end else if (cnt_done) begin
          state_d = sync_ctrl_pkg::GRP_RUN;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = sync_ctrl_pkg::GRP_RUN;
      end
    endcase
  end

  // State, counter and run flag registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= sync_ctrl_pkg::GRP_RUN;
      cnt_q <= '0;
      group_run_q <= 1'b1;
      half_step_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      group_run_q <= (state_d == sync_ctrl_pkg::GRP_RUN);
      // Half step follows the register at once, no sync needed
      half_step_q <= half_step_cfg;
    end
  end

endmodule : sync_group_delay

`default_nettype wire

/* File: design/sync_output_control.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module sync_output_control #(
  parameter int NUM_GROUPS = sync_ctrl_pkg::NUM_GROUPS,
  parameter int SYNC_STAGES = sync_ctrl_pkg::SYNC_STAGES
) (
  input wire logic clock,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [sync_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sync_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sync pin level and loop lock indicators
  input wire logic sync_pin,
  input wire logic loop1_lock_indicator,
  input wire logic loop2_lock_indicator,
  // Per group run flag and half step advance
  output logic [NUM_GROUPS-1:0] group_run,
  output logic [NUM_GROUPS-1:0] group_half_step,
  // Latched sync state
  output logic sync_latched
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int GIDX_W = sync_ctrl_pkg::ADDR_W - 2;
  localparam int WCNT_W = 3;
  // Group index of output_three and output_four
  localparam int OUT3_GROUP = 3;
  localparam int OUT4_GROUP = 4;

  // Registers held by software
  sync_ctrl_pkg::ctrl_s ctrl_q;  // Global sync control
  sync_ctrl_pkg::group_cfg_s group_cfg_q [NUM_GROUPS];  // Per group
  logic [sync_ctrl_pkg::LOOP2_DIV_W-1:0] loop2_div_q;  // Loop 2 divider

  // Byte lane merge of new write data into an old word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // ---------------- Write channel ----------------
  logic aw_got_q;  // Write address captured
  logic w_got_q;  // Write data captured
  logic [sync_ctrl_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Write happens once both halves are in and no response is pending
  wire logic do_write = aw_got_q && w_got_q && !s_axi_bvalid;
  wire logic [GIDX_W-1:0] wr_index = awaddr_q[sync_ctrl_pkg::ADDR_W-1:2];
  wire logic wr_group = (wr_index < GIDX_W'(NUM_GROUPS));
  wire logic wr_loop2 = (awaddr_q == sync_ctrl_pkg::LOOP2_DIV_OFFSET);
  wire logic wr_ctrl = (awaddr_q == sync_ctrl_pkg::CTRL_OFFSET);
  wire logic wr_status = (awaddr_q == sync_ctrl_pkg::STATUS_OFFSET);
  wire logic wr_mapped = wr_group || wr_loop2 || wr_ctrl || wr_status;

  // Current contents of the addressed group register as a word
  logic [31:0] wr_group_word;
  logic [31:0] wr_group_new;
  always_comb begin
    wr_group_word = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (wr_index == GIDX_W'(g)) begin
        wr_group_word[sync_ctrl_pkg::GROUP_COARSE_LSB +:
          sync_ctrl_pkg::COARSE_W] = group_cfg_q[g].coarse_delay_count;
        wr_group_word[sync_ctrl_pkg::GROUP_HALF_STEP_BIT] =
          group_cfg_q[g].half_step_delay;
        wr_group_word[sync_ctrl_pkg::GROUP_EXCLUDE_BIT] =
          group_cfg_q[g].group_sync_exclude;
      end
    end
    wr_group_new = merge_bytes(wr_group_word, wdata_q, wstrb_q);
  end

  wire logic [31:0] wr_ctrl_new =
    merge_bytes({21'h0, ctrl_q}, wdata_q, wstrb_q);
  wire logic [31:0] wr_loop2_new =
    merge_bytes({14'h0, loop2_div_q}, wdata_q, wstrb_q);

  // Address and data handshakes, taken in either order
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status is read only, so a write there is refused too
        s_axi_bresp <= (wr_mapped && !wr_status) ? RESP_OKAY : RESP_SLVERR;
      end
      // Ready comes back only after the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register file updates
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q <= sync_ctrl_pkg::CTRL_RESET;
      loop2_div_q <= sync_ctrl_pkg::LOOP2_DIV_RESET;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        group_cfg_q[g] <= {1'b0, 1'b0, sync_ctrl_pkg::COARSE_RESET};
      end
    end else if (do_write) begin
      if (wr_ctrl) begin
        ctrl_q <= wr_ctrl_new[10:0];
      end
      if (wr_loop2) begin
        loop2_div_q <= wr_loop2_new[sync_ctrl_pkg::LOOP2_DIV_W-1:0];
      end
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (wr_group && wr_index == GIDX_W'(g)) begin
          group_cfg_q[g] <= {
            wr_group_new[sync_ctrl_pkg::GROUP_EXCLUDE_BIT],
            wr_group_new[sync_ctrl_pkg::GROUP_HALF_STEP_BIT],
            wr_group_new[sync_ctrl_pkg::GROUP_COARSE_LSB +:
              sync_ctrl_pkg::COARSE_W]};
        end
      end
    end
  end

  // ---------------- Sync request sources ----------------
  // Register writes that raise a sync event
  wire logic write_sync_trig = do_write && (
    (wr_group && ctrl_q.auto_sync) ||
    (wr_loop2 && ctrl_q.internal_vco));

  // Stretches a write trigger so the latch sees more than one cycle
  logic [WCNT_W-1:0] write_sync_cnt_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      write_sync_cnt_q <= '0;
    end else if (write_sync_trig) begin
      write_sync_cnt_q <= WCNT_W'(sync_ctrl_pkg::WRITE_SYNC_CYCLES);
    end else if (write_sync_cnt_q != '0) begin
      write_sync_cnt_q <= write_sync_cnt_q - WCNT_W'(1);
    end
  end
  wire logic write_sync_req = (write_sync_cnt_q != '0);

  // Pin synchroniser; only the last stage is looked at
  logic [SYNC_STAGES-1:0] pin_sync_q;
  logic [1:0] lock_q;  // Lock indicators, registered once
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_sync_q <= '0;
      lock_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[SYNC_STAGES-2:0], sync_pin};
      lock_q <= {loop2_lock_indicator, loop1_lock_indicator};
    end
  end
  wire logic pin_level = pin_sync_q[SYNC_STAGES-1];

  // Input types compare the pin with the invert bit; output types use
  // the invert bit alone, so toggling it raises or drops sync directly
  wire logic pin_is_output =
    (ctrl_q.sync_type >= sync_ctrl_pkg::SYNC_TYPE_OUT_MIN);
  wire logic manual_req = pin_is_output ? ctrl_q.sync_polarity_invert
    : (pin_level != ctrl_q.sync_polarity_invert);
  wire logic unlock_req =
    (ctrl_q.loop1_unlock_sync && !lock_q[0]) ||
    (ctrl_q.loop2_unlock_sync && !lock_q[1]);
  wire logic sync_req = ctrl_q.sync_enable &&
    (manual_req || unlock_req || write_sync_req);

  // ---------------- Latch and latency ----------------
  // The latch point is this flop; the cycle it catches a slow pin edge
  // on is not fixed, so callers must not rely on one cycle
  logic latched_q;
  logic [sync_ctrl_pkg::SYNC_LATENCY-1:0] hold_pipe_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      latched_q <= 1'b0;
      hold_pipe_q <= '0;
      sync_latched <= 1'b0;
    end else begin
      latched_q <= sync_req;
      hold_pipe_q <= {hold_pipe_q[sync_ctrl_pkg::SYNC_LATENCY-2:0],
        latched_q};
      sync_latched <= sync_req;
    end
  end

  // Assertion reaches the groups six cycles after the latch edge
  localparam int HOLD_TAP = sync_ctrl_pkg::SYNC_LATENCY - 2;
  wire logic assert_pulse =
    hold_pipe_q[HOLD_TAP] && !hold_pipe_q[HOLD_TAP+1];
  // Release runs down the same delay line as assertion, so a request
  // shorter than the latency can never leave the groups held for good
  wire logic release_pulse =
    !hold_pipe_q[HOLD_TAP] && hold_pipe_q[HOLD_TAP+1];

  // ---------------- Output groups ----------------
  // Reference-sourced groups sit outside sync; the reference oscillator
  // output itself is not a group and is never touched here
  logic [NUM_GROUPS-1:0] ref_sourced;
  logic [NUM_GROUPS-1:0] participate;
  always_comb begin
    ref_sourced = '0;
    ref_sourced[OUT3_GROUP] = ctrl_q.out3_ref_source_sel;
    ref_sourced[OUT4_GROUP] = ctrl_q.out4_ref_source_sel;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      participate[g] = !group_cfg_q[g].group_sync_exclude &&
        !ref_sourced[g];
    end
  end

  // Same sequencer per group, so equal delays rise together
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_group
    sync_group_delay #(
      .COARSE_W(sync_ctrl_pkg::COARSE_W)
    ) u_group (
      .clock(clock),
      .reset(reset),
      .participate(participate[g]),
      .assert_pulse(assert_pulse),
      .release_pulse(release_pulse),
      .coarse_cfg(group_cfg_q[g].coarse_delay_count),
      .half_step_cfg(group_cfg_q[g].half_step_delay),
      .group_run_q(group_run[g]),
      .half_step_q(group_half_step[g])
    );
  end

  // ---------------- Read channel ----------------
  wire logic [GIDX_W-1:0] rd_index = s_axi_araddr[sync_ctrl_pkg::ADDR_W-1:2];
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (rd_index < GIDX_W'(NUM_GROUPS)) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (rd_index == GIDX_W'(g)) begin
          rd_word[sync_ctrl_pkg::GROUP_COARSE_LSB +:
            sync_ctrl_pkg::COARSE_W] = group_cfg_q[g].coarse_delay_count;
          rd_word[sync_ctrl_pkg::GROUP_HALF_STEP_BIT] =
            group_cfg_q[g].half_step_delay;
          rd_word[sync_ctrl_pkg::GROUP_EXCLUDE_BIT] =
            group_cfg_q[g].group_sync_exclude;
        end
      end
    end else if (s_axi_araddr == sync_ctrl_pkg::LOOP2_DIV_OFFSET) begin
      rd_word[sync_ctrl_pkg::LOOP2_DIV_W-1:0] = loop2_div_q;
    end else if (s_axi_araddr == sync_ctrl_pkg::CTRL_OFFSET) begin
      rd_word[10:0] = ctrl_q;
    end else if (s_axi_araddr == sync_ctrl_pkg::STATUS_OFFSET) begin
      rd_word[sync_ctrl_pkg::STATUS_LATCHED_BIT] = latched_q;
      rd_word[sync_ctrl_pkg::STATUS_HOLD_BIT] =
        hold_pipe_q[sync_ctrl_pkg::SYNC_LATENCY-1];
      rd_word[sync_ctrl_pkg::STATUS_RUN_LSB +: NUM_GROUPS] = group_run;
    end else begin
      // Unmapped addresses read zero with an error response
      rd_hit = 1'b0;
    end
  end

  // One read at a time; address ready drops until data is taken
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : sync_output_control

`default_nettype wire

/* File: sim/sync_output_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the sync controller
module sync_output_control_asserts #(
  parameter int NUM_GROUPS = 6
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_GROUPS-1:0] group_run,
  input wire logic sync_latched
);
  // Cycles since the latch last dropped, saturating
  logic [10:0] low_cnt_q;

  // Counter gives the restart check an exact floor
  always_ff @(posedge clock) begin
    if (reset || sync_latched) begin
      low_cnt_q <= 11'h000;
    end else if (low_cnt_q != 11'h7ff) begin
      low_cnt_q <= low_cnt_q + 11'h001;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_fall_after_latch: assert property (
    |($past(group_run) & ~group_run) |-> $past(sync_latched, 6))
    else $error("group fell without a latch six cycles before");
  a_rise_after_release: assert property (
    |(~$past(group_run) & group_run) |-> !sync_latched && low_cnt_q >= 11)
    else $error("group restarted too early");
  a_no_rise_latched: assert property (
    sync_latched && $past(sync_latched)
      |-> (group_run & ~$past(group_run)) == '0)
    else $error("group restarted while sync held");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready during response");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");

  c_release: cover property ($fell(sync_latched));
  c_all_held: cover property (group_run == '0);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : sync_output_control_asserts

bind sync_output_control sync_output_control_asserts #(
  .NUM_GROUPS(NUM_GROUPS)
) chk (
  .clock(clock),
  .reset(reset),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .group_run(group_run),
  .sync_latched(sync_latched)
);

`default_nettype wire

/* File: sim/sync_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side: drives the sync pin and the two lock indicators
module sync_host_model (
  input wire logic clock,
  output logic sync_pin,
  output logic loop1_lock_indicator,
  output logic loop2_lock_indicator
);
  // Pin idle, both loops locked from time zero
  initial begin
    sync_pin = 1'b0;
    loop1_lock_indicator = 1'b1;
    loop2_lock_indicator = 1'b1;
  end

  // Level change just after an edge, held at least seven cycles
  task automatic set_pin(input logic level);
    @(posedge clock);
    sync_pin <= level;
    repeat (7) @(posedge clock);
  endtask : set_pin

  // Lock indicator of one loop
  task automatic set_lock(input int loop_sel, input logic locked);
    @(posedge clock);
    if (loop_sel == 0) begin
      loop1_lock_indicator <= locked;
    end else begin
      loop2_lock_indicator <= locked;
    end
  endtask : set_lock
endmodule : sync_host_model

`default_nettype wire

/* File: sim/sync_output_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_output_control_bench;
  localparam logic [7:0] CTRL = sync_ctrl_pkg::CTRL_OFFSET;
  localparam logic [7:0] DIV = sync_ctrl_pkg::LOOP2_DIV_OFFSET;
  localparam logic [7:0] STAT = sync_ctrl_pkg::STATUS_OFFSET;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sync_latched;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sync_pin, lock1, lock2;
  logic [5:0] group_run, half_step;
  int n_mismatch = 0;
  int cmp_count = 0;
  int rise_t [6];
  int cfg;
  logic held;  // Expected hold in the sync type sweep

  // 20 MHz distribution clock
  always #25 clock = ~clock;

  sync_host_model host (.clock(clock), .sync_pin(sync_pin),
    .loop1_lock_indicator(lock1), .loop2_lock_indicator(lock2));

  sync_output_control dut (.clock(clock), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sync_pin(sync_pin),
    .loop1_lock_indicator(lock1), .loop2_lock_indicator(lock2),
    .group_run(group_run), .group_half_step(half_step),
    .sync_latched(sync_latched));

  // Compare one word, count it, report a mismatch at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // Write: address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] exp);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, exp});
  endtask : wr

  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] exp_resp);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, exp_resp});
  endtask : rd

  // Edges from the release latch to each group's restart
  task automatic measure();
    int n;
    n = 0;
    while (sync_latched !== 1'b0 && n < 30) begin
      @(posedge clock);
      n++;
    end
    rise_t = '{default: -1};
    for (n = 0; n < 40; n++) begin
      foreach (rise_t[g]) begin
        if (rise_t[g] < 0 && group_run[g] === 1'b1) rise_t[g] = n;
      end
      @(posedge clock);
    end
  endtask : measure

  // Whether a latch appears in the next twelve edges
  task automatic seen_latch(input logic exp);
    logic f;
    f = 1'b0;
    repeat (12) begin
      @(posedge clock);
      if (sync_latched === 1'b1) f = 1'b1;
    end
    check({31'h0, f}, {31'h0, exp});
  endtask : seen_latch

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog, well above the few thousand cycles the tests need
  initial begin
    tick(20000);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    tick(4);
    reset <= 1'b0;
    rd(CTRL, 32'h101, 2'b00);
    rd(8'h00, 32'h5, 2'b00);
    rd(DIV, 32'h1, 2'b00);
    rd(8'hfc, 32'h0, 2'b10);
    wr(STAT, 32'h0, 2'b10);
    // Low byte lane only: the exclude bit in the top byte must not land
    wstrb <= 4'h1;
    wr(8'h10, 32'h0100_0005, 2'b00);
    wstrb <= 4'hf;
    rd(8'h10, 32'h5, 2'b00);
    wr(8'h04, 32'h0100_0005, 2'b00);
    wr(8'h08, 32'h8, 2'b00);
    wr(CTRL, 32'h301, 2'b00);
    host.set_pin(1'b1);
    tick(8);
    check({26'h0, group_run}, 32'h0a);
    // Watch from before the release so its latch edge is not missed
    fork
      host.set_pin(1'b0);
      measure();
    join
    check(rise_t[0], 11);
    check(rise_t[1], 0);
    check(rise_t[2], 14);
    check(rise_t[3], 0);
    check(rise_t[4], 11);
    rd(STAT, 32'h3f00, 2'b00);
    // Coarse waits for a sync, half step does not
    wr(8'h00, 32'h9, 2'b00);
    wr(8'h14, 32'h0001_0005, 2'b00);
    wr(CTRL, 32'h501, 2'b00);
    tick(2);
    check({26'h0, group_run}, 32'h3f);
    check({26'h0, half_step}, 32'h20);
    host.set_pin(1'b1);
    tick(8);
    check({26'h0, group_run}, 32'h12);
    fork
      host.set_pin(1'b0);
      measure();
    join
    check(rise_t[0], 15);
    check(rise_t[3], 11);
    check(rise_t[4], 0);
    check(rise_t[5], 11);
    // Sync types 0 to 6 against pin level and invert bit
    for (int t = 0; t < 7; t++) begin
      for (int c = 0; c < 4; c++) begin
        cfg = 32'h300 | (t << 2) | ((c & 1) << 1);
        wr(CTRL, cfg, 2'b00);
        host.set_pin(c[1]);
        tick(5);
        check({31'h0, sync_latched}, 32'h0);
        wr(CTRL, cfg | 1, 2'b00);
        tick(15);
        held = (t < 3) ? (c[1] ^ c[0]) : c[0];
        check({31'h0, sync_latched}, {31'h0, held});
        check({26'h0, group_run}, held ? 32'h0a : 32'h3f);
        wr(CTRL, cfg, 2'b00);
        tick(30);
        check({26'h0, group_run}, 32'h3f);
      end
    end
    host.set_pin(1'b0);
    // Loss of lock holds sync while the loop is unlocked
    for (int l = 0; l < 2; l++) begin
      wr(CTRL, 32'h301 | (32'h40 << l), 2'b00);
      host.set_lock(l, 1'b0);
      tick(15);
      check({31'h0, sync_latched}, 32'h1);
      host.set_lock(l, 1'b1);
      tick(30);
      check({26'h0, group_run}, 32'h3f);
    end
    // Register writes that raise a sync; groups must come back after
    wr(CTRL, 32'h301, 2'b00);
    wr(DIV, 32'h20, 2'b00);
    seen_latch(1'b1);
    tick(40);
    check({26'h0, group_run}, 32'h3f);
    wr(CTRL, 32'h201, 2'b00);
    wr(DIV, 32'h21, 2'b00);
    seen_latch(1'b0);
    wr(8'h00, 32'h9, 2'b00);
    seen_latch(1'b0);
    wr(CTRL, 32'h221, 2'b00);
    wr(8'h00, 32'h9, 2'b00);
    seen_latch(1'b1);
    tick(40);
    check({26'h0, group_run}, 32'h3f);
    report_and_stop();
  end
endmodule : sync_output_control_bench

`default_nettype wire
